// [hw/eio_port.sv]
// eight-bit io port: control registers, output latch, pin drive and read path
`timescale 1ns/1ps

module eio_port #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [eio_pkg::ADDR_W-1:0] addr,
  input wire logic [eio_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [eio_pkg::DATA_W-1:0] rdata,
  input wire logic [WIDTH-1:0] pin_in_schmitt,
  input wire logic [WIDTH-1:0] pin_in_ttl,
  input wire logic [WIDTH-1:0] route_sel,
  input wire logic [WIDTH-1:0] route_data,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_slew_limit,
  output logic [WIDTH-1:0] pin_thr_sel,
  output logic [WIDTH-1:0] analog_connect,
  output logic [WIDTH-1:0] change_level
);
  import eio_pkg::*;

  // refuse widths the register port cannot carry
  if (WIDTH < 1 || WIDTH > DATA_W) begin : g_bad_width
    $error("eio_port: WIDTH must lie between 1 and the register data width");
  end

  // all state of the port
  typedef struct packed {
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] lat;
    logic [WIDTH-1:0] ods;
    logic [WIDTH-1:0] slew;
    logic [WIDTH-1:0] thr;
    logic [WIDTH-1:0] ana;
    logic [WIDTH-1:0] pins_rd;
    logic [WIDTH-1:0] drv_out;
    logic [WIDTH-1:0] drv_oe;
    logic [WIDTH-1:0] slew_q;
    logic [WIDTH-1:0] thr_q;
    logic [WIDTH-1:0] ana_q;
    logic [DATA_W-1:0] rdata;
  } eio_state_t;

  eio_state_t s;
  eio_state_t next_s;

  // zero extension of a port-wide value to the register data width
  function automatic logic [DATA_W-1:0] eio_zext(input logic [WIDTH-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    r[WIDTH-1:0] = v;
    return r;
  endfunction : eio_zext

  logic [WIDTH-1:0] wdata_w;
  logic [WIDTH-1:0] src_word;
  logic [WIDTH-1:0] cell_out;
  logic [WIDTH-1:0] cell_oe;
  logic [WIDTH-1:0] cell_rd;
  logic [WIDTH-1:0] cell_ana;

  // write data cut to the port width
  assign wdata_w = wdata[WIDTH-1:0];

  // pin source: latch unless the routing logic claims the pin
  assign src_word = (route_sel & route_data) | (~route_sel & s.lat);

  // one cell per pin
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    eio_pin_cell u_cell (
      .dir(s.dir[i]),
      .src(src_word[i]),
      .od(s.ods[i]),
      .ana(s.ana[i]),
      .thr(s.thr[i]),
      .in_schmitt(pin_in_schmitt[i]),
      .in_ttl(pin_in_ttl[i]),
      .drv_out(cell_out[i]),
      .drv_oe(cell_oe[i]),
      .rd_val(cell_rd[i]),
      .ana_on(cell_ana[i])
    );
  end

  // next state: register writes, pin sampling, drive and read data
  always_comb begin
    next_s = s;
    if (ce) begin
      // pin levels as the digital input path sees them
      next_s.pins_rd = cell_rd;
      next_s.drv_out = cell_out;
      next_s.drv_oe = cell_oe;
      next_s.slew_q = s.slew;
      next_s.thr_q = s.thr;
      next_s.ana_q = cell_ana;
      if (wr) begin
        unique case (addr)
          A_PINS: next_s.lat = wdata_w; // every bit addressed, latch not pins
          A_PSET: next_s.lat = s.pins_rd | wdata_w; // read pins, modify, store
          A_PCLR: next_s.lat = s.pins_rd & ~wdata_w;
          A_PTGL: next_s.lat = s.pins_rd ^ wdata_w;
          A_DIR: next_s.dir = wdata_w;
          A_LAT: next_s.lat = wdata_w;
          A_ODS: next_s.ods = wdata_w;
          A_SLEW: next_s.slew = wdata_w;
          A_THR: next_s.thr = wdata_w;
          A_ANA: next_s.ana = wdata_w;
          default: next_s.lat = s.lat; // unmapped write ignored
        endcase
      end
      // read data stand one cycle after the strobe only
      next_s.rdata = '0;
      if (rd) begin
        unique case (addr)
          A_PINS: next_s.rdata = eio_zext(s.pins_rd); // pins, not latch
          A_DIR: next_s.rdata = eio_zext(s.dir);
          A_LAT: next_s.rdata = eio_zext(s.lat); // stored latch
          A_ODS: next_s.rdata = eio_zext(s.ods);
          A_SLEW: next_s.rdata = eio_zext(s.slew);
          A_THR: next_s.rdata = eio_zext(s.thr);
          A_ANA: next_s.rdata = eio_zext(s.ana);
          default: next_s.rdata = '0; // set/clear/toggle and unmapped read zero
        endcase
      end
    end
  end

  // state register with reset defaults
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s.dir <= {WIDTH{RST_DIR}};
      s.lat <= {WIDTH{RST_LAT}};
      s.ods <= {WIDTH{RST_ODS}};
      s.slew <= {WIDTH{RST_SLEW}};
      s.thr <= {WIDTH{RST_THR}};
      s.ana <= {WIDTH{RST_ANA}};
      s.pins_rd <= '0;
      s.drv_out <= '0;
      s.drv_oe <= '0;
      s.slew_q <= {WIDTH{RST_SLEW}};
      s.thr_q <= {WIDTH{RST_THR}};
      s.ana_q <= {WIDTH{RST_ANA}};
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign rdata = s.rdata;
  assign pin_out = s.drv_out;
  assign pin_oe = s.drv_oe;
  assign pin_slew_limit = s.slew_q;
  assign pin_thr_sel = s.thr_q;
  assign analog_connect = s.ana_q;
  assign change_level = s.pins_rd; // interrupt-on-change compare level

  // helper words read only by the checks
  logic [WIDTH-1:0] pp_mask;
  logic [WIDTH-1:0] rd_expect;
  logic [DATA_W-1:0] lat_word;
  logic [DATA_W-1:0] pins_word;

  assign pp_mask = ~s.dir & ~s.ods;
  assign rd_expect = ~s.ana & ((s.thr & pin_in_schmitt) | (~s.thr & pin_in_ttl));
  assign lat_word = eio_zext(s.lat);
  assign pins_word = eio_zext(s.pins_rd);

  // input pins never drive
  chk_input_hiz: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> ((pin_oe & $past(s.dir)) == '0))
    else $error("pin driver on while direction is input");

  // push-pull outputs drive the source value
  chk_push_drive: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> (((pin_oe & $past(pp_mask)) == $past(pp_mask))
      && (((pin_out ^ $past(src_word)) & $past(pp_mask)) == '0)))
    else $error("push-pull output not driving source");

  // open drain never drives a one
  chk_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> (((pin_out & pin_oe) & $past(s.ods)) == '0))
    else $error("open-drain pin driven high");

  // analog pins read zero, others follow the chosen threshold
  chk_read_path: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> (s.pins_rd == $past(rd_expect)))
    else $error("digital read path wrong");

  // latch read returns the latch, a cycle later
  chk_latch_read: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && rd && addr == A_LAT) |=> (rdata == $past(lat_word)))
    else $error("latch read mismatch");

  // port read returns the sampled pins
  chk_pins_read: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && rd && addr == A_PINS) |=> (rdata == $past(pins_word)))
    else $error("port read not the pin levels");

  // read data only in the cycle after a strobe
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !rd) |=> (rdata == '0))
    else $error("read data outside its cycle");

  // set through the port is read-modify-write on pins
  chk_rmw_set: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr && addr == A_PSET) |=> (s.lat == ($past(s.pins_rd) | $past(wdata_w))))
    else $error("port set not based on pin levels");

  // clear through the port starts from pin levels too
  chk_rmw_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr && addr == A_PCLR) |=> (s.lat == ($past(s.pins_rd) & ~$past(wdata_w))))
    else $error("port clear not based on pin levels");

  // toggle through the port starts from pin levels too
  chk_rmw_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr && addr == A_PTGL) |=> (s.lat == ($past(s.pins_rd) ^ $past(wdata_w))))
    else $error("port toggle not based on pin levels");

  // a port write reaches the latch on the next edge
  chk_port_write: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr && addr == A_PINS && $past(ce)) |=> (s.lat == $past(wdata_w)))
    else $error("port write did not reach latch");

  // slew and analog switch follow their select bits
  chk_slew_ana: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> ((pin_slew_limit == $past(s.slew)) && (analog_connect == $past(s.ana))))
    else $error("slew or analog switch not following select");

  // analog mode and a cleared latch right after reset
  chk_reset_default: assert property (@(posedge clk_sys)
    (!rst && $past(rst)) |-> ((s.ana == '1) && (s.lat == '0)))
    else $error("reset defaults wrong");

  // clock enable low freezes everything
  chk_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    !ce |=> $stable(s))
    else $error("state moved with clock enable low");

  // main scenarios
  cov_port_set: cover property (@(posedge clk_sys) disable iff (rst)
    ce && wr && addr == A_PSET ##1 ce && rd && addr == A_LAT);
  cov_analog_output: cover property (@(posedge clk_sys) disable iff (rst)
    ce && (s.ana & ~s.dir) != '0 ##1 pin_oe != '0);
  cov_open_drain_low: cover property (@(posedge clk_sys) disable iff (rst)
    ce && (s.ods & ~s.dir & ~s.lat) != '0 ##1 (pin_oe & ~pin_out) != '0);
  cov_pins_read: cover property (@(posedge clk_sys) disable iff (rst)
    ce && rd && addr == A_PINS ##1 rdata != '0);

endmodule : eio_port

// [inc/eio_pkg.sv]
// constants shared by the eight-bit io port and its pin cell
package eio_pkg;

  // register port geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] A_PINS = 4'h0; // read pins, write latch
  localparam logic [ADDR_W-1:0] A_PSET = 4'h1; // pins or mask into latch
  localparam logic [ADDR_W-1:0] A_PCLR = 4'h2; // pins and not mask into latch
  localparam logic [ADDR_W-1:0] A_PTGL = 4'h3; // pins xor mask into latch
  localparam logic [ADDR_W-1:0] A_DIR = 4'h4; // direction_control
  localparam logic [ADDR_W-1:0] A_LAT = 4'h5; // output_latch
  localparam logic [ADDR_W-1:0] A_ODS = 4'h6; // open_drain_select
  localparam logic [ADDR_W-1:0] A_SLEW = 4'h7; // slew_limit_select
  localparam logic [ADDR_W-1:0] A_THR = 4'h8; // input_threshold_select
  localparam logic [ADDR_W-1:0] A_ANA = 4'h9; // analog_input_select

  // per-bit reset values, replicated over the port width
  localparam logic RST_DIR = 1'b1; // input
  localparam logic RST_LAT = 1'b0;
  localparam logic RST_ODS = 1'b0; // push-pull
  localparam logic RST_SLEW = 1'b1; // limited
  localparam logic RST_THR = 1'b0; // ttl levels
  localparam logic RST_ANA = 1'b1; // analog mode

  // threshold select encoding
  localparam logic THR_SCHMITT = 1'b1;
  localparam logic THR_TTL = 1'b0;

endpackage : eio_pkg

// [hw/eio_pin_cell.sv]
// one pin of the io port: drive decision and digital input path
`timescale 1ns/1ps

module eio_pin_cell (
  input wire logic dir,
  input wire logic src,
  input wire logic od,
  input wire logic ana,
  input wire logic thr,
  input wire logic in_schmitt,
  input wire logic in_ttl,
  output logic drv_out,
  output logic drv_oe,
  output logic rd_val,
  output logic ana_on
);
  import eio_pkg::*;

  // driver: direction first, then open-drain or push-pull
  // analog select takes no part here
  assign drv_oe = ~dir & ~(od & src);
  assign drv_out = od ? 1'b0 : src; // open drain never drives high

  // input path: threshold picks comparator, analog mode reads zero
  assign rd_val = ana ? 1'b0 : ((thr == THR_SCHMITT) ? in_schmitt : in_ttl);

  // analog switch closes only in analog mode
  assign ana_on = ana;

endmodule : eio_pin_cell

// [verif/eio_pad_model.sv]
// board side of the port: pull-ups, an external driver and analog-level pins
`timescale 1ns/1ps

module eio_pad_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] mid,
  output logic [7:0] pin_in_schmitt,
  output logic [7:0] pin_in_ttl
);
  logic [7:0] lvl;
  logic [7:0] amb;
  // driver wins, else external source, else pull-up on a released line
  assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
  // a mid-rail level reads high on ttl and low on schmitt
  assign amb = mid & ~pin_oe;
  assign pin_in_ttl = lvl | amb;
  assign pin_in_schmitt = lvl & ~amb;
endmodule : eio_pad_model

// [verif/tb_top.sv]
// self-checking bench for the eight-bit io port
`timescale 1ns/1ps

module tb_top;
  import eio_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [7:0] sch, ttl, pin_out, pin_oe, slew, thr_sel, ana_con, chg;
  logic [7:0] mid = 8'h00;
  logic ce = 1'b1;
  logic [7:0] route_sel = 8'h00;
  logic [7:0] route_data = 8'h00;
  int err_total = 0;
  int cmp_count = 0;
  logic [ADDR_W-1:0] rst_addr [6];
  logic [7:0] rst_exp [6];

  always #20 clk_sys = ~clk_sys;

  eio_port #(.WIDTH(8)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in_schmitt(sch), .pin_in_ttl(ttl), .route_sel(route_sel),
    .route_data(route_data), .pin_out(pin_out), .pin_oe(pin_oe), .pin_slew_limit(slew),
    .pin_thr_sel(thr_sel), .analog_connect(ana_con), .change_level(chg));

  // low nibble driven from outside to 5, high nibble left to the port
  eio_pad_model pad_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(8'h0F), .ext_val(8'h05),
    .mid(mid), .pin_in_schmitt(sch), .pin_in_ttl(ttl));

  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wreg

  // one-cycle read strobe, data checked in the following cycle
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rchk

  // let register changes reach the pads and the pin sample
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  // hang guard
  initial begin
    #400000;
    err_total++;
    results();
  end

  // main sequence
  initial begin
    rst_addr = '{A_DIR, A_LAT, A_ODS, A_SLEW, A_THR, A_ANA};
    rst_exp = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    for (int i = 0; i < 6; i++) begin
      rchk(rst_addr[i], rst_exp[i]);
    end
    chk(pin_oe, 8'h00);
    chk(ana_con, 8'hFF);
    rchk(A_PINS, 8'h00);
    // digital setup: high nibble outputs
    wreg(A_ANA, 8'h00);
    wreg(A_DIR, 8'h0F);
    wreg(A_PINS, 8'h3C);
    settle();
    chk(pin_oe, 8'hF0);
    chk(pin_out, 8'h3C);
    chk(ana_con, 8'h00);
    rchk(A_PINS, 8'h35);
    rchk(A_LAT, 8'h3C);
    // open drain: ones released to pull-up, zeros sunk
    wreg(A_ODS, 8'hFF);
    settle();
    chk(pin_oe, 8'hC0);
    chk(pin_out, 8'h00);
    rchk(A_PINS, 8'h35);
    wreg(A_ODS, 8'h00);
    settle();
    chk(pin_oe, 8'hF0);
    chk(pin_out, 8'h3C);
    // read-modify-write through the pins, each followed by a settle
    wreg(A_PSET, 8'h80);
    settle();
    rchk(A_LAT, 8'hB5);
    wreg(A_PCLR, 8'h10);
    settle();
    rchk(A_LAT, 8'hA5);
    wreg(A_PTGL, 8'hFF);
    settle();
    rchk(A_LAT, 8'h5A);
    chk(pin_out, 8'h5A);
    rchk(A_PINS, 8'h55);
    // analog on driven pins keeps the drive, zeroes the reads
    wreg(A_ANA, 8'hF0);
    settle();
    chk(pin_oe, 8'hF0);
    chk(pin_out, 8'h5A);
    chk(ana_con, 8'hF0);
    rchk(A_PINS, 8'h05);
    wreg(A_ANA, 8'hFF);
    wreg(A_DIR, 8'h00);
    settle();
    chk(pin_oe, 8'hFF);
    rchk(A_PINS, 8'h00);
    chk(chg, 8'h00);
    wreg(A_DIR, 8'h0F);
    wreg(A_ANA, 8'h00);
    // mid-rail level on inputs; thresholds changed with no peripheral active
    mid <= 8'h0F;
    wreg(A_THR, 8'h00);
    settle();
    rchk(A_PINS, 8'h5F);
    chk(chg, 8'h5F);
    wreg(A_THR, 8'hFF);
    settle();
    chk(thr_sel, 8'hFF);
    rchk(A_PINS, 8'h50);
    chk(chg, 8'h50);
    rchk(A_THR, 8'hFF);
    // slew limit follows its register
    wreg(A_SLEW, 8'h00);
    settle();
    chk(slew, 8'h00);
    rchk(A_SLEW, 8'h00);
    wreg(A_SLEW, 8'hA5);
    settle();
    chk(slew, 8'hA5);
    // unmapped and write-only places read zero
    wreg(4'hF, 8'hFF);
    rchk(4'hF, 8'h00);
    rchk(A_PSET, 8'h00);
    rchk(A_LAT, 8'h5A);
    // routing claims the high nibble, latch keeps its value
    @(posedge clk_sys);
    route_sel <= 8'hF0;
    route_data <= 8'hA0;
    settle();
    chk(pin_out, 8'hAA);
    rchk(A_PINS, 8'hA0);
    rchk(A_LAT, 8'h5A);
    // clock enable low ignores a write and holds the pins
    @(posedge clk_sys);
    ce <= 1'b0;
    route_sel <= 8'h00;
    wreg(A_LAT, 8'h00);
    settle();
    chk(pin_out, 8'hAA);
    @(posedge clk_sys);
    ce <= 1'b1;
    settle();
    chk(pin_out, 8'h5A);
    rchk(A_LAT, 8'h5A);
    // reset in mid-run brings the defaults back
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    chk(pin_oe, 8'h00);
    chk(ana_con, 8'hFF);
    rchk(A_PINS, 8'h00);
    rchk(A_LAT, 8'h00);
    results();
  end
endmodule : tb_top
